// ===== logic/lab_pkg.sv
// Shared constants and types of the logic, average and branch executor
package lab_pkg;
    localparam int DATA_W      = 32;
    localparam int HALF_W      = 16;
    localparam int BYTE_W      = 8;
    localparam int DISP_W      = 21;
    localparam int DISP_SHIFT  = 2;
    localparam int DELAY_SLOTS = 5;
    localparam int SLOT_W      = 3;
    localparam logic [SLOT_W-1:0] SLOT_ZERO = 3'h0;
    localparam logic [SLOT_W-1:0] SLOT_LOAD = 3'(DELAY_SLOTS);
    localparam logic [DATA_W-1:0] ZERO_WORD = 32'h0000_0000;
    localparam logic [4:0]        ZERO_REG  = 5'h00;

    // Operation codes presented by the decoder
    typedef enum logic [2:0] {
        LAB_OP_NONE,
        LAB_OP_AND_INVERT_OP,
        LAB_OP_AVGH,
        LAB_OP_AVGB,
        LAB_OP_BDISP,
        LAB_OP_BREG
    } lab_op_t;

    // Functional unit that issued the operation
    typedef enum logic [2:0] {
        LAB_U_L1, LAB_U_L2, LAB_U_S1, LAB_U_S2,
        LAB_U_D1, LAB_U_D2, LAB_U_M1, LAB_U_M2
    } lab_unit_t;
endpackage

// ===== logic/lab_avg_if.sv
// Carrier between the executor and its packed-average unit
interface lab_avg_if;
    import lab_pkg::*;
    logic              start;
    logic              byte_mode;
    logic [DATA_W-1:0] a;
    logic [DATA_W-1:0] b;
    logic [DATA_W-1:0] result;
    logic              done;
    modport exec (output start, byte_mode, a, b, input result, done);
    modport unit (input start, byte_mode, a, b, output result, done);
endinterface

// ===== logic/lab_avg_unit.sv
// Two-cycle packed halfword and byte average unit
module lab_avg_unit (
    // Clock and reset
    input  wire logic core_clk_i,
    input  wire logic nrst_i,
    // Executor side
    lab_avg_if.unit   avg
);
    import lab_pkg::*;

    // Rounded average of one byte lane, unsigned
    function automatic logic [BYTE_W-1:0] avg_byte(
        input logic [BYTE_W-1:0] x, input logic [BYTE_W-1:0] y);
        logic [BYTE_W:0] s;
        s = {1'b0, x} + {1'b0, y} + 9'h001;
        return s[BYTE_W:1];
    endfunction

    // Rounded average of one halfword lane, signed
    function automatic logic [HALF_W-1:0] avg_half(
        input logic [HALF_W-1:0] x, input logic [HALF_W-1:0] y);
        logic signed [HALF_W:0] s;
        s = $signed({x[HALF_W-1], x}) + $signed({y[HALF_W-1], y})
            + 17'sh00001;
        return s[HALF_W:1];
    endfunction

    logic [DATA_W-1:0] lane_nxt;

    // Lanes never carry into each other, so no overflow exists
    genvar g;
    generate
        for (g = 0; g < DATA_W / HALF_W; g++) begin : g_half
            logic [HALF_W-1:0] hres;
            logic [HALF_W-1:0] bres;
            assign hres = avg_half(avg.a[g*HALF_W +: HALF_W],
                                   avg.b[g*HALF_W +: HALF_W]);
            assign bres = {avg_byte(avg.a[g*HALF_W+BYTE_W +: BYTE_W],
                                    avg.b[g*HALF_W+BYTE_W +: BYTE_W]),
                           avg_byte(avg.a[g*HALF_W +: BYTE_W],
                                    avg.b[g*HALF_W +: BYTE_W])};
            assign lane_nxt[g*HALF_W +: HALF_W] = avg.byte_mode ? bres : hres;
        end
    endgenerate

    // Result register gives the one delay slot
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            avg.result <= ZERO_WORD;
            avg.done   <= 1'b0;
        end else begin
            avg.done <= avg.start;
            if (avg.start) begin
                avg.result <= lane_nxt;
            end
        end
    end
endmodule

// ===== logic/lab_exec.sv
// Executor for and-invert, packed averages and the two branch forms
// Operation
// - and_invert_op gives src1 AND NOT src2
// - Halfword average rounds, one delay slot
// - Signed halfword lanes independent, no overflow
// - Byte average rounds, one delay slot
// - Unsigned byte lanes independent, no overflow
// - Displacement branch: disp shifted two plus base
// - Base is first address of E1 packet
// - Two taken branches per packet undefined
// - Delay-slot packets block interrupts
// - Five delay slots, target in cycle six
// - Split target packet stalls on enhanced core
// - Register branch loads src2, side2 S only
module lab_exec #(
    parameter bit ENHANCED = 1'b1
) (
    // Clock and reset
    input  wire logic                       core_clk_i,
    input  wire logic                       nrst_i,
    // Issued instruction in E1
    input  wire logic                       issue_i,
    input  wire lab_pkg::lab_op_t           op_i,
    input  wire lab_pkg::lab_unit_t         unit_i,
    input  wire logic                       cond_i,
    input  wire logic [4:0]                 dst_i,
    input  wire logic [lab_pkg::DATA_W-1:0] src1_i,
    input  wire logic [lab_pkg::DATA_W-1:0] src2_i,
    input  wire logic [lab_pkg::DISP_W-1:0] disp_const_i,
    input  wire logic [lab_pkg::DATA_W-1:0] packet_base_pc_i,
    input  wire logic                       pkt_has_pc_constant_add_op_i,
    // Fetch state
    input  wire logic                       target_split_i,
    input  wire logic                       second_fetch_ok_i,
    // Register write
    output logic                            wr_en_o,
    output logic [4:0]                      wr_dst_o,
    output logic [lab_pkg::DATA_W-1:0]      wr_data_o,
    // Branch and pipeline control
    output logic                            fc_load_o,
    output logic [lab_pkg::DATA_W-1:0]      fetch_counter_o,
    output logic                            int_block_o,
    output logic                            stall_o,
    output logic                            illegal_o
);
    import lab_pkg::*;

    lab_avg_if avg ();

    lab_avg_unit u_avg (
        .core_clk_i (core_clk_i),
        .nrst_i     (nrst_i),
        .avg        (avg)
    );

    // Unit legality for each operation
    function automatic logic unit_ok(input lab_op_t o, input lab_unit_t u);
        unique case (o)
            LAB_OP_AND_INVERT_OP:  return !(u inside {LAB_U_M1, LAB_U_M2});
            LAB_OP_AVGH,
            LAB_OP_AVGB:  return u inside {LAB_U_M1, LAB_U_M2};
            LAB_OP_BDISP: return u inside {LAB_U_S1, LAB_U_S2};
            LAB_OP_BREG:  return u == LAB_U_S2;
            LAB_OP_NONE:  return 1'b0;
            default:      return 1'b0; // Spare codes never issue
        endcase
    endfunction

    logic               legal;
    logic               go;
    logic               is_branch;
    logic               pc_constant_add_op_clash;
    logic [DATA_W-1:0]  disp_ext;
    logic [SLOT_W-1:0]  slot_r;
    logic [SLOT_W-1:0]  slot_nxt;
    logic               avg_pend_r;
    logic [4:0]         avg_dst_r;
    logic               split_r;

    // Condition gates writes and branch loads; the delay-slot counter and the illegal flag ignore it
    assign is_branch    = op_i inside {LAB_OP_BDISP, LAB_OP_BREG};
    assign pc_constant_add_op_clash = (op_i == LAB_OP_BDISP) && pkt_has_pc_constant_add_op_i;
    assign legal = unit_ok(op_i, unit_i) && !pc_constant_add_op_clash;
    assign go    = issue_i && legal && cond_i;
    assign disp_ext = DATA_W'(signed'(disp_const_i)) << DISP_SHIFT;

    // Packed average launches into the two-cycle unit
    assign avg.start     = go && (op_i inside {LAB_OP_AVGH, LAB_OP_AVGB});
    assign avg.byte_mode = (op_i == LAB_OP_AVGB);
    assign avg.a         = src1_i;
    assign avg.b         = src2_i;

    // Remember destination across the delay slot
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            avg_pend_r <= 1'b0;
            avg_dst_r  <= ZERO_REG;
        end else begin
            avg_pend_r <= avg.start;
            if (avg.start) begin
                avg_dst_r <= dst_i;
            end
        end
    end

    // Write port: single-cycle result beats a finishing average; the beaten average is never written
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            wr_en_o   <= 1'b0;
            wr_dst_o  <= ZERO_REG;
            wr_data_o <= ZERO_WORD;
        end else if (go && op_i == LAB_OP_AND_INVERT_OP) begin
            wr_en_o   <= 1'b1;
            wr_dst_o  <= dst_i;
            wr_data_o <= src1_i & ~src2_i;
        end else if (avg.done && avg_pend_r) begin
            wr_en_o   <= 1'b1;
            wr_dst_o  <= avg_dst_r;
            wr_data_o <= avg.result;
        end else begin
            wr_en_o   <= 1'b0;
        end
    end

    // Branch target into fetch counter; base is the E1 packet address
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            fc_load_o       <= 1'b0;
            fetch_counter_o <= ZERO_WORD;
        end else begin
            fc_load_o <= go && is_branch;
            if (go && op_i == LAB_OP_BDISP) begin
                fetch_counter_o <= packet_base_pc_i + disp_ext;
            end else if (go && op_i == LAB_OP_BREG) begin
                fetch_counter_o <= src2_i;
            end
        end
    end

    // Delay-slot counter runs taken or not
    always_comb begin
        slot_nxt = slot_r;
        if (issue_i && legal && is_branch) begin
            slot_nxt = SLOT_LOAD;
        end else if (slot_r != SLOT_ZERO && !stall_o) begin
            slot_nxt = slot_r - 3'h1;
        end
    end

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            slot_r      <= SLOT_ZERO;
            int_block_o <= 1'b0;
        end else begin
            slot_r      <= slot_nxt;
            int_block_o <= slot_nxt != SLOT_ZERO;
        end
    end

    // Split target packet waits for its second half
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            split_r <= 1'b0;
            stall_o <= 1'b0;
        end else begin
            if (go && is_branch) begin
                split_r <= ENHANCED && target_split_i;
            end else if (stall_o && second_fetch_ok_i) begin
                split_r <= 1'b0;
            end
            stall_o <= split_r && slot_r == 3'h1 && !second_fetch_ok_i
                       || stall_o && !second_fetch_ok_i;
        end
    end

    // Flag bad unit or forbidden pairing; undefined cases are not decoded
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            illegal_o <= 1'b0;
        end else begin
            illegal_o <= issue_i && op_i != LAB_OP_NONE && !legal;
        end
    end

    // Assertions
    and_invert_op_result_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        go && op_i == LAB_OP_AND_INVERT_OP |=> wr_en_o && wr_data_o ==
        ($past(src1_i) & ~$past(src2_i))) else $error("and_invert_op wrong");
    // Average launch not overtaken by an and-invert write
    sequence avg_launch_s;
        avg.start ##1 !(go && op_i == LAB_OP_AND_INVERT_OP);
    endsequence
    avg_latency_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        avg_launch_s |=> wr_en_o && wr_dst_o == $past(dst_i, 2))
        else $error("average not written");
    avgh_value_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        avg.start && !avg.byte_mode |=> avg.result[HALF_W-1:0] ==
        16'(($signed({$past(src1_i[15]), $past(src1_i[15:0])}) +
        $signed({$past(src2_i[15]), $past(src2_i[15:0])}) + 1) >>> 1))
        else $error("half average wrong");
    avgb_value_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        avg.start && avg.byte_mode |=> avg.result[7:0] ==
        8'((9'($past(src1_i[7:0])) + 9'($past(src2_i[7:0])) + 9'h1) >> 1))
        else $error("byte average wrong");
    bdisp_target_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        go && op_i == LAB_OP_BDISP |=> fc_load_o && fetch_counter_o ==
        $past(packet_base_pc_i) + ($past(disp_ext)))
        else $error("branch target wrong");
    breg_unit_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        issue_i && op_i == LAB_OP_BREG && unit_i != LAB_U_S2 |=> !fc_load_o)
        else $error("register branch off S2");
    nop_false_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        issue_i && !cond_i && !avg_pend_r |=> !wr_en_o && !fc_load_o &&
        $stable(fetch_counter_o)) else $error("false cond acted");
    sequence br_issue_s;
        issue_i && legal && is_branch && !stall_o;
    endsequence
    slot_block_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        br_issue_s ##1 (!issue_i && !stall_o) [*4] |-> int_block_o)
        else $error("slot not blocked");

    // Upper halfword lane computed on its own
    avgh_upper_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        avg.start && !avg.byte_mode |=> avg.result[31:16] ==
        16'(($signed({$past(src1_i[31]), $past(src1_i[31:16])}) +
        $signed({$past(src2_i[31]), $past(src2_i[31:16])}) + 1) >>> 1))
        else $error("upper half average wrong");

    // Remaining byte lanes, no carry between them
    avgb_lane1_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        avg.start && avg.byte_mode |=> avg.result[15:8] ==
        8'((9'($past(src1_i[15:8])) + 9'($past(src2_i[15:8])) + 9'h1) >> 1))
        else $error("byte lane 1 wrong");
    avgb_lane2_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        avg.start && avg.byte_mode |=> avg.result[23:16] ==
        8'((9'($past(src1_i[23:16])) + 9'($past(src2_i[23:16])) + 9'h1) >> 1))
        else $error("byte lane 2 wrong");
    avgb_lane3_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        avg.start && avg.byte_mode |=> avg.result[31:24] ==
        8'((9'($past(src1_i[31:24])) + 9'($past(src2_i[31:24])) + 9'h1) >> 1))
        else $error("byte lane 3 wrong");

    // Unit checks and the and-invert destination: averages need a multiplier unit
    avg_unit_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        issue_i && op_i inside {LAB_OP_AVGH, LAB_OP_AVGB} &&
        !(unit_i inside {LAB_U_M1, LAB_U_M2}) |=> !avg.done)
        else $error("average on wrong unit");
    and_invert_op_unit_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        issue_i && op_i == LAB_OP_AND_INVERT_OP && unit_i inside {LAB_U_M1, LAB_U_M2}
        && !(avg.done && avg_pend_r) |=> !wr_en_o)
        else $error("and-invert on multiplier");
    and_invert_op_dst_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        go && op_i == LAB_OP_AND_INVERT_OP |=> wr_dst_o == $past(dst_i))
        else $error("and-invert destination wrong");
    bdisp_unit_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        issue_i && op_i == LAB_OP_BDISP &&
        !(unit_i inside {LAB_U_S1, LAB_U_S2}) |=> !fc_load_o)
        else $error("displacement branch off S unit");

    // Branch targets and refused pairings
    breg_target_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        go && op_i == LAB_OP_BREG |=> fc_load_o &&
        fetch_counter_o == $past(src2_i))
        else $error("register target wrong");
    pc_constant_add_op_block_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        issue_i && op_i == LAB_OP_BDISP && pkt_has_pc_constant_add_op_i |=>
        !fc_load_o && illegal_o)
        else $error("branch with pc add acted");
    illegal_flag_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        issue_i && op_i != LAB_OP_NONE && !legal |=> illegal_o && !fc_load_o)
        else $error("illegal issue not flagged");

    // Delay-slot window opens on issue and closes after five
    slot_load_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        issue_i && legal && is_branch |=> int_block_o && slot_r == SLOT_LOAD)
        else $error("slot window not opened");
    slot_release_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        slot_r == 3'h1 && !stall_o && !(issue_i && legal && is_branch)
        |=> !int_block_o)
        else $error("slot window not closed");

    // Stall holds until the second fetch packet is in
    stall_hold_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        stall_o && !second_fetch_ok_i |=> stall_o)
        else $error("stall dropped early");
    stall_clear_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        stall_o && second_fetch_ok_i |=> !stall_o)
        else $error("stall stuck");

    // Nothing issued or predicated off writes a register or moves the fetch counter
    wr_idle_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        !(go && op_i == LAB_OP_AND_INVERT_OP) && !(avg.done && avg_pend_r)
        |=> !wr_en_o)
        else $error("spurious write");
    fc_hold_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        !go |=> !fc_load_o && $stable(fetch_counter_o))
        else $error("fetch counter moved");
endmodule

// ===== sim/logic_avg_branch_exec_tb_top.sv
// Self-checking bench of the logic, average and branch executor
module logic_avg_branch_exec_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import lab_pkg::*;

    // Stimulus and observed signals
    logic              core_clk_i        = 1'b0;
    logic              nrst_i            = 1'b0;
    logic              issue_i           = 1'b0;
    lab_op_t           op_i              = LAB_OP_NONE;
    lab_unit_t         unit_i            = LAB_U_L1;
    logic              cond_i            = 1'b1;
    logic [4:0]        dst_i             = 5'h0b;
    logic [DATA_W-1:0] src1_i            = ZERO_WORD;
    logic [DATA_W-1:0] src2_i            = ZERO_WORD;
    logic [DISP_W-1:0] disp_const_i      = 21'h1fff00;
    logic [DATA_W-1:0] packet_base_pc_i  = 32'h0100_0000;
    logic              pkt_has_pc_constant_add_op_i  = 1'b0;
    logic              target_split_i    = 1'b0;
    logic              second_fetch_ok_i = 1'b1;
    logic              wr_en_o;
    logic [4:0]        wr_dst_o;
    logic [DATA_W-1:0] wr_data_o;
    logic              fc_load_o;
    logic [DATA_W-1:0] fetch_counter_o;
    logic              int_block_o;
    logic              stall_o;
    logic              illegal_o;
    int                num_errors        = 0;
    int                compares          = 0;
    int                cycles            = 0;

    lab_exec uut (
        .core_clk_i(core_clk_i), .nrst_i(nrst_i), .issue_i(issue_i),
        .op_i(op_i), .unit_i(unit_i), .cond_i(cond_i), .dst_i(dst_i),
        .src1_i(src1_i), .src2_i(src2_i), .disp_const_i(disp_const_i),
        .packet_base_pc_i(packet_base_pc_i),
        .pkt_has_pc_constant_add_op_i(pkt_has_pc_constant_add_op_i),
        .target_split_i(target_split_i),
        .second_fetch_ok_i(second_fetch_ok_i), .wr_en_o(wr_en_o),
        .wr_dst_o(wr_dst_o), .wr_data_o(wr_data_o), .fc_load_o(fc_load_o),
        .fetch_counter_o(fetch_counter_o), .int_block_o(int_block_o),
        .stall_o(stall_o), .illegal_o(illegal_o));

    // Clock, 100 MHz
    always #5 core_clk_i = ~core_clk_i;

    // Hang guard, far above the fewer than a hundred cycles the run needs
    always @(posedge core_clk_i) begin
        cycles++;
        if (cycles == 2000) begin
            num_errors++;
            finish_test();
        end
    end

    task automatic finish_test();
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] exp,
                       input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // One instruction in E1 for one edge; returns at the next falling edge
    task automatic issue(input lab_op_t op, input lab_unit_t un,
                         input logic cd, input logic [31:0] s1,
                         input logic [31:0] s2);
        @(negedge core_clk_i);
        issue_i = 1'b1;
        op_i = op;
        unit_i = un;
        cond_i = cd;
        src1_i = s1;
        src2_i = s2;
        @(negedge core_clk_i);
        issue_i = 1'b0;
    endtask

    // Write pulse must land exactly lat cycles after issue, or in none of the three checked cycles if 0
    task automatic run_alu(input lab_op_t op, input lab_unit_t un,
                           input logic cd, input logic [31:0] s1,
                           input logic [31:0] s2, input logic [31:0] exp,
                           input int lat, input logic ill);
        issue(op, un, cd, s1, s2);
        for (int k = 1; k <= 3; k++) begin
            if (k == 1) chk("illegal_o", 32'(ill), 32'(illegal_o));
            chk("wr_en_o", 32'(k == lat), 32'(wr_en_o));
            if (k == lat) chk("wr_data_o", exp, wr_data_o);
            if (k == lat) chk("wr_dst_o", 32'(dst_i), 32'(wr_dst_o));
            if (k < 3) @(negedge core_clk_i);
        end
    endtask

    // Load pulse one cycle after issue, five blocked slots, free in cycle 6
    task automatic run_br(input lab_op_t op, input lab_unit_t un,
                          input logic cd, input logic [31:0] s2,
                          input logic ld, input logic [31:0] fc,
                          input logic ill);
        issue(op, un, cd, ZERO_WORD, s2);
        chk("fc_load_o", 32'(ld), 32'(fc_load_o));
        chk("illegal_o", 32'(ill), 32'(illegal_o));
        chk("fetch_counter_o", fc, fetch_counter_o);
        for (int k = 1; k <= 6; k++) begin
            chk("int_block_o", 32'(k <= 5 && !ill), 32'(int_block_o));
            if (k < 6) @(negedge core_clk_i);
        end
    endtask

    task automatic t_and_invert_op();
        run_alu(LAB_OP_AND_INVERT_OP, LAB_U_L1, 1'b1, 32'h1957_21ab, 32'h081c_17e6,
                32'h1143_2009, 1, 1'b0);
        run_alu(LAB_OP_AND_INVERT_OP, LAB_U_D2, 1'b1, 32'hffff_0000, 32'h0f0f_0f0f,
                32'hf0f0_0000, 1, 1'b0);
    endtask

    task automatic t_avgh();
        run_alu(LAB_OP_AVGH, LAB_U_M1, 1'b1, 32'h6198_4357, 32'h7582_ae15,
                32'h6b8d_f8b6, 2, 1'b0);
        run_alu(LAB_OP_AVGH, LAB_U_M2, 1'b1, 32'h7fff_8000, 32'h7fff_8000,
                32'h7fff_8000, 2, 1'b0);
    endtask

    task automatic t_avgb();
        run_alu(LAB_OP_AVGB, LAB_U_M1, 1'b1, 32'h1a2e_5f4e, 32'h9ef2_6e3f,
                32'h5c90_6747, 2, 1'b0);
        run_alu(LAB_OP_AVGB, LAB_U_M2, 1'b1, 32'hff00_ff01, 32'hff01_0000,
                32'hff01_8001, 2, 1'b0);
    endtask

    // Sign-extended displacement times four plus packet base
    task automatic t_bdisp();
        logic [31:0] tgt;
        tgt = packet_base_pc_i + {{9{disp_const_i[20]}}, disp_const_i, 2'b00};
        run_br(LAB_OP_BDISP, LAB_U_S1, 1'b1, ZERO_WORD, 1'b1, tgt,
               1'b0);
    endtask

    task automatic t_breg();
        run_br(LAB_OP_BREG, LAB_U_S2, 1'b1, 32'h1000_000c, 1'b1,
               32'h1000_000c, 1'b0);
        run_br(LAB_OP_BREG, LAB_U_S1, 1'b1, 32'h2000_0000, 1'b0,
               32'h1000_000c, 1'b1);
    endtask

    // False predicate: no write, counter kept, slots still blocked
    task automatic t_nop();
        run_alu(LAB_OP_AND_INVERT_OP, LAB_U_S1, 1'b0, 32'hffff_ffff, ZERO_WORD,
                ZERO_WORD, 0, 1'b0);
        run_br(LAB_OP_BREG, LAB_U_S2, 1'b0, 32'h3000_0000, 1'b0,
               32'h1000_000c, 1'b0);
    endtask

    task automatic t_pc_constant_add_op();
        pkt_has_pc_constant_add_op_i = 1'b1;
        run_br(LAB_OP_BDISP, LAB_U_S2, 1'b1, ZERO_WORD, 1'b0,
               32'h1000_000c, 1'b1);
        pkt_has_pc_constant_add_op_i = 1'b0;
    endtask

    // Split target holds the stall until the second fetch packet arrives
    task automatic t_stall();
        int n;
        target_split_i = 1'b1;
        second_fetch_ok_i = 1'b0;
        issue(LAB_OP_BREG, LAB_U_S2, 1'b1, ZERO_WORD, 32'h1000_0040);
        target_split_i = 1'b0;
        repeat (7) @(negedge core_clk_i);
        chk("stall_o", 32'h1, 32'(stall_o));
        second_fetch_ok_i = 1'b1;
        n = 0;
        while (stall_o !== 1'b0 && n < 4) begin
            @(negedge core_clk_i);
            n++;
        end
        chk("stall_o", 32'h0, 32'(stall_o));
        chk("fetch_counter_o", 32'h1000_0040, fetch_counter_o);
    endtask

    // Main sequence
    initial begin
        repeat (4) @(posedge core_clk_i);
        @(negedge core_clk_i);
        nrst_i = 1'b1;
        t_and_invert_op();
        t_avgh();
        t_avgb();
        t_bdisp();
        t_breg();
        t_nop();
        t_pc_constant_add_op();
        t_stall();
        finish_test();
    end
endmodule
